// *** hdl/gpmc_regs.vh ***
`ifndef GPMC_REGS_VH
`define GPMC_REGS_VH
`define GPMC_NUM_PINS      24
`define GPMC_MODE_W        4
`define GPMC_MODE_ANALOG   4'h0
`define GPMC_MODE_IN_FLOAT 4'h4
`define GPMC_MODE_IN_PULL  4'h8
`define GPMC_MODE_OUT_PP   4'h1
`define GPMC_MODE_OUT_OD   4'h5
`define GPMC_MODE_ALT_PP   4'h9
`define GPMC_MODE_ALT_OD   4'hd
`define GPMC_MODE_ALT_SCK  4'hb
`define GPMC_MODE_RESET    4'h4
`define GPMC_OUT_RESET     24'h000000
`define GPMC_REG_PIN       7
`endif

// *** hdl/gpmc_top.v ***
// Overview of operation
// - each of 24 pins independently takes one of eight io modes.
// - synchronised pin level feeds input register and peripheral inputs, except on analog pins.
// - wake path gated by wake enable; interrupt path only on capable pins.
// - analog mode replaces pin input with constant one.
// - exactly one source, output register or peripheral, sets each output.
// - normal modes drive output register bit; alternate modes drive peripheral.
// - input and analog modes keep the output driver off.
// - regulator pin pulled low in deep sleep when used, else released.
// - four-bit mode code decoded to analog, inputs, outputs, alternates.
// - pulled input uses pull-up if output bit set, else pull-down.
// - alternate mode without owning peripheral outputs zero.
// - clear and set strobes change output bits; zero bits untouched.
`include "gpmc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module gpmc_top (
  input  wire        clk_in,
  input  wire        resetn_in,
  input  wire [95:0] mode_cfg_in,
  input  wire        mode_cfg_we_in,
  input  wire [23:0] out_level_wdata_in,
  input  wire        out_level_we_in,
  input  wire [23:0] output_bit_clear_reg_in,
  input  wire        output_bit_clear_we_in,
  input  wire [23:0] output_bit_set_reg_in,
  input  wire        output_bit_set_we_in,
  input  wire [23:0] periph_out_in,
  input  wire [23:0] periph_present_in,
  input  wire [23:0] wake_en_in,
  input  wire [23:0] irq_capable_in,
  input  wire        ext_reg_en_in,
  input  wire        deep_sleep_in,
  input  wire [23:0] pin_in,
  output wire [23:0] pin_out,
  output wire [23:0] pin_oe_out,
  output reg  [23:0] pull_en_out,
  output reg  [23:0] pull_up_out,
  output reg  [23:0] analog_en_out,
  output reg  [23:0] pin_input_level_reg_out,
  output reg  [23:0] periph_in_out,
  output reg  [23:0] wake_in_out,
  output reg  [23:0] irq_in_out,
  output reg  [23:0] pin_output_level_reg_out,
  output reg  [95:0] mode_cfg_out
);
////////////////////////////////////////////////////////////////////////////////
// input synchroniser
reg [23:0] sync1_r;
reg [23:0] sync2_r;
always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    sync1_r <= 24'h000000;
    sync2_r <= 24'h000000;
  end else begin
    sync1_r <= pin_in;
    sync2_r <= sync1_r;
  end
end
////////////////////////////////////////////////////////////////////////////////
// configuration and output level registers
reg [23:0] odr_nxt;
always @* begin
  odr_nxt = pin_output_level_reg_out;
  if (out_level_we_in)
    odr_nxt = out_level_wdata_in;
  if (output_bit_clear_we_in)
    odr_nxt = odr_nxt & ~output_bit_clear_reg_in;
  if (output_bit_set_we_in)
    odr_nxt = odr_nxt | output_bit_set_reg_in;
end
always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    pin_output_level_reg_out <= `GPMC_OUT_RESET;
    mode_cfg_out             <= {24{`GPMC_MODE_RESET}};
  end else begin
    pin_output_level_reg_out <= odr_nxt;
    if (mode_cfg_we_in)
      mode_cfg_out <= mode_cfg_in;
  end
end
////////////////////////////////////////////////////////////////////////////////
// per-pin mode decode
wire [23:0] dec_val;
wire [23:0] dec_oe;
wire [23:0] dec_pull_en;
wire [23:0] dec_pull_up;
wire [23:0] dec_analog;
genvar g;
generate
  for (g = 0; g < `GPMC_NUM_PINS; g = g + 1) begin : g_pin
    gpmc_pin_dec u_dec (
      .mode_in       (mode_cfg_out[g*4 +: 4]),
      .odr_bit_in    (pin_output_level_reg_out[g]),
      .periph_out_in (periph_out_in[g]),
      .periph_own_in (periph_present_in[g]),
      .val_out       (dec_val[g]),
      .oe_out        (dec_oe[g]),
      .pull_en_out   (dec_pull_en[g]),
      .pull_up_out   (dec_pull_up[g]),
      .analog_out    (dec_analog[g])
    );
  end
endgenerate
////////////////////////////////////////////////////////////////////////////////
// regulator pin override and input level
reg [23:0] drive_r;
reg [23:0] oe_r;
reg [23:0] val_nxt;
reg [23:0] oe_nxt;
reg [23:0] pull_en_nxt;
reg [23:0] pull_up_nxt;
reg [23:0] analog_nxt;
reg [23:0] lvl_nxt;
always @* begin
  val_nxt     = dec_val;
  oe_nxt      = dec_oe;
  pull_en_nxt = dec_pull_en;
  pull_up_nxt = dec_pull_up;
  analog_nxt  = dec_analog;
  if (ext_reg_en_in) begin
    val_nxt[`GPMC_REG_PIN]     = 1'b0;
    oe_nxt[`GPMC_REG_PIN]      = deep_sleep_in;
    pull_en_nxt[`GPMC_REG_PIN] = 1'b0;
    pull_up_nxt[`GPMC_REG_PIN] = 1'b0;
    analog_nxt[`GPMC_REG_PIN]  = 1'b0;
  end
  // analog pins read as one after the override
  lvl_nxt = analog_nxt | sync2_r;
end
////////////////////////////////////////////////////////////////////////////////
// registered outputs
always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    drive_r                 <= 24'h000000;
    oe_r                    <= 24'h000000;
    pull_en_out             <= 24'h000000;
    pull_up_out             <= 24'h000000;
    analog_en_out           <= 24'h000000;
    pin_input_level_reg_out <= 24'h000000;
    periph_in_out           <= 24'h000000;
    wake_in_out             <= 24'h000000;
    irq_in_out              <= 24'h000000;
  end else begin
    drive_r                 <= val_nxt;
    oe_r                    <= oe_nxt;
    pull_en_out             <= pull_en_nxt;
    pull_up_out             <= pull_up_nxt;
    analog_en_out           <= analog_nxt;
    pin_input_level_reg_out <= lvl_nxt;
    periph_in_out           <= lvl_nxt;
    wake_in_out             <= lvl_nxt & wake_en_in;
    irq_in_out              <= lvl_nxt & irq_capable_in;
  end
end
assign pin_out    = drive_r;
assign pin_oe_out = oe_r;
endmodule // gpmc_top
////////////////////////////////////////////////////////////////////////////////
// one pin's mode decode
module gpmc_pin_dec (
  input  wire [3:0] mode_in,
  input  wire       odr_bit_in,
  input  wire       periph_out_in,
  input  wire       periph_own_in,
  output reg        val_out,
  output reg        oe_out,
  output reg        pull_en_out,
  output reg        pull_up_out,
  output reg        analog_out
);
reg src;
reg od;
always @* begin
  src         = 1'b0;
  od          = 1'b0;
  val_out     = 1'b0;
  oe_out      = 1'b0;
  pull_en_out = 1'b0;
  pull_up_out = 1'b0;
  analog_out  = 1'b0;
  case (mode_in)
    `GPMC_MODE_ANALOG: begin
      analog_out = 1'b1;
    end
    `GPMC_MODE_IN_FLOAT: begin
      oe_out = 1'b0;
    end
    `GPMC_MODE_IN_PULL: begin
      pull_en_out = 1'b1;
      pull_up_out = odr_bit_in;
    end
    `GPMC_MODE_OUT_PP: begin
      src    = odr_bit_in;
      oe_out = 1'b1;
    end
    `GPMC_MODE_OUT_OD: begin
      src    = odr_bit_in;
      od     = 1'b1;
      oe_out = 1'b1;
    end
    `GPMC_MODE_ALT_PP, `GPMC_MODE_ALT_SCK: begin
      src    = periph_own_in & periph_out_in;
      oe_out = 1'b1;
    end
    `GPMC_MODE_ALT_OD: begin
      src    = periph_own_in & periph_out_in;
      od     = 1'b1;
      oe_out = 1'b1;
    end
    default: begin
      oe_out = 1'b0;
    end
  endcase
  val_out = src;
  if (od) begin
    val_out = 1'b0;
    oe_out  = ~src;
  end
end
endmodule // gpmc_pin_dec
`default_nettype wire

// *** testbench/gpmc_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpmc_chk (
  input wire clk_in, resetn_in, output_bit_set_we_in, ext_reg_en_in, deep_sleep_in,
  input wire [23:0] periph_out_in, periph_present_in, output_bit_set_reg_in, pin_out,
  input wire [23:0] pin_oe_out, pin_output_level_reg_out,
  input wire [95:0] mode_cfg_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire [3:0] m0 = mode_cfg_out[3:0];
  wire       lv = pin_output_level_reg_out[0];
  sequence sleep_s; (ext_reg_en_in && deep_sleep_in) [*3]; endsequence
  in_oe_off_a: assert property (m0 inside {4'h0, 4'h4, 4'h8} |=> !pin_oe_out[0])
    else $error("oe on");
  pp_drive_a: assert property (m0 == 4'h1 |=> pin_oe_out[0] && pin_out[0] == $past(lv))
    else $error("pp");
  od_drive_a: assert property (m0 == 4'h5 |=> !pin_out[0] && pin_oe_out[0] == !$past(lv))
    else $error("od");
  alt_drive_a: assert property (m0 == 4'h9 |=>
    pin_out[0] == ($past(periph_out_in[0]) & $past(periph_present_in[0]))) else $error("alt");
  alt_od_a: assert property (m0 == 4'hd |=> !pin_out[0]) else $error("alt od");
  set_bit_a: assert property (output_bit_set_we_in && output_bit_set_reg_in[0] |=> lv)
    else $error("set");
  reg_low_a: assert property (sleep_s |-> pin_oe_out[7] && !pin_out[7]) else $error("reg");
  reg_rel_a: assert property ((ext_reg_en_in && !deep_sleep_in) [*3] |-> !pin_oe_out[7])
    else $error("rel");
endmodule // gpmc_chk
bind gpmc_top gpmc_chk i_chk(.*);
`default_nettype wire

// *** testbench/gpmc_board.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpmc_board (
  input  wire [23:0] drv_in, oe_in, ext_in,
  output wire [23:0] pad_out
);
  // board drives every pad the device releases
  assign pad_out = oe_in & drv_in | ~oe_in & ext_in;
endmodule // gpmc_board
`default_nettype wire

// *** testbench/test_gpio_pin_mode_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH %0t value", $time); end end
module test_gpio_pin_mode_control;
  logic clk_in = 0, resetn_in = 0, wr = 0, ext_reg_en_in = 0, deep_sleep_in = 0;
  logic [95:0] mode_cfg_in = 0;
  logic [23:0] out_level_wdata_in = 0, output_bit_clear_reg_in = 0, output_bit_set_reg_in = 0;
  logic [23:0] periph_out_in = 0, periph_present_in = 0, wake_en_in = 0, irq_capable_in = 0;
  logic [23:0] ext = 0, v, o, p, dq, de, pe, an;
  wire mode_cfg_we_in = wr, out_level_we_in = wr;
  wire output_bit_clear_we_in = wr, output_bit_set_we_in = wr;
  wire [23:0] pin_in, pin_out, pin_oe_out, pull_en_out, pull_up_out, analog_en_out;
  wire [23:0] pin_input_level_reg_out, periph_in_out, wake_in_out, irq_in_out;
  wire [23:0] pin_output_level_reg_out;
  wire [95:0] mode_cfg_out;
  wire [335:0] seen = {pin_input_level_reg_out, pin_output_level_reg_out, pin_out,
    pin_oe_out, pull_en_out, pull_up_out, analog_en_out, periph_in_out, wake_in_out,
    irq_in_out, mode_cfg_out};
  int errors = 0, check_count = 0, cyc = 0, seed = 12967;
  logic [335:0] q[$];
  logic [3:0] codes[8] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h5, 4'h9, 4'hd, 4'hb};
  gpmc_top i_dut(.*);
  gpmc_board i_board(.drv_in(pin_out), .oe_in(pin_oe_out), .ext_in(ext), .pad_out(pin_in));
  always #12.5 clk_in = ~clk_in;
  task end_of_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_in) if (++cyc == 1500) begin
    errors++;
    end_of_test();
  end
  always @(negedge clk_in)
    if (q.size() > 0) `CHK(q.pop_front(), seen)
  task automatic step();
    @(posedge clk_in);
    for (int i = 0; i < 24; i++) mode_cfg_in[4*i+:4] <= codes[3'($random(seed))];
    {out_level_wdata_in, output_bit_clear_reg_in, output_bit_set_reg_in, periph_out_in} <=
      {$random(seed), $random(seed), $random(seed)};
    {periph_present_in, ext, ext_reg_en_in, deep_sleep_in} <= 50'({$random(seed), $random(seed)});
    {wake_en_in, irq_capable_in} <= 48'({$random(seed), $random(seed)});
    wr <= 1;
    @(posedge clk_in);
    wr <= 0;
    o = (out_level_wdata_in & ~output_bit_clear_reg_in) | output_bit_set_reg_in;
    p = periph_out_in & periph_present_in;
    for (int i = 0; i < 24; i++) begin
      {dq[i], de[i], pe[i], an[i]} = 4'h0;
      case (mode_cfg_in[4*i+:4])
        4'h0: begin v[i] = 1'b1; an[i] = 1'b1; end
        4'h1: begin v[i] = o[i]; dq[i] = o[i]; de[i] = 1'b1; end
        4'h5: begin v[i] = o[i] & ext[i]; de[i] = ~o[i]; end
        4'h9, 4'hb: begin v[i] = p[i]; dq[i] = p[i]; de[i] = 1'b1; end
        4'hd: begin v[i] = p[i] & ext[i]; de[i] = ~p[i]; end
        4'h8: begin v[i] = ext[i]; pe[i] = 1'b1; end
        default: v[i] = ext[i];
      endcase
    end
    if (ext_reg_en_in) begin
      v[7] = !deep_sleep_in & ext[7];
      {dq[7], de[7], pe[7], an[7]} = {1'b0, deep_sleep_in, 2'b00};
    end
    repeat (6) @(posedge clk_in);
    q.push_back({v, o, dq, de, pe, pe & o, an, v, v & wake_en_in, v & irq_capable_in,
      mode_cfg_in});
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    resetn_in <= 1;
    repeat (100) step();
    repeat (2) @(posedge clk_in);
    end_of_test();
  end
endmodule // test_gpio_pin_mode_control
`default_nettype wire
